/* up_mode_timer_compare.sv */
// Up mode timer with compare channels, interrupt vector and APB slave
//
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/100ps
`include "tmr_defs.svh"

// Functional notes
// RULE_01: In up mode the overflow flag is set only when the count passes from period to zero.
// RULE_02: Writing the count clear bit forces the count to zero, running or not.
// RULE_03: A restart after stop at period and clear gives no overflow on the first timer edge.
// RULE_04: The counter runs from the external timer clock pin or the auxiliary clock.
// RULE_05: A channel in compare mode flags when the count becomes equal to its compare value.
// RULE_06: A compare value raised by one before the next increment still flags on reaching it.
// RULE_07: A power-up clear returns control and interrupt vector to reset regardless of activity.
// RULE_08: A full-word write of the control register also clears the interrupt vector.
// RULE_09: Software initialises the control register after reset with one full-word write.
// RULE_10: Every increment, the first after a clear too, follows the input divider.
module up_mode_timer_compare #(
	parameter int NCH = 3
) (
	// Clock and reset
	input  wire logic                 CLK,
	input  wire logic                 RST_N,
	// Power-up clear from the watchdog unit
	input  wire logic                 POWER_UP_CLEAR,
	// APB slave
	input  wire logic                 PSEL,
	input  wire logic                 PENABLE,
	input  wire logic                 PWRITE,
	input  wire logic [`TMR_AW-1:0]   PADDR,
	input  wire logic [`TMR_DW-1:0]   PWDATA,
	input  wire logic [3:0]           PSTRB,
	output logic [`TMR_DW-1:0]        PRDATA,
	output logic                      PREADY,
	output logic                      PSLVERR,
	// Timer clock sources
	input  wire logic                 EXTERNAL_TIMER_CLOCK,
	input  wire logic                 AUX_CLOCK,
	// Interrupt
	output logic                      IRQ
);

	localparam int NS = NCH + 1;

	tmr_pkg::apb_req_s       req;
	tmr_pkg::ctrl_s          ctrl_r;
	tmr_pkg::ctrl_s          ctrl_nxt;
	logic [NS-1:0]           status_r;
	logic [NS-1:0]           status_nxt;
	logic [NS-1:0]           ien_r;
	logic [NS-1:0]           ien_nxt;
	logic [`TMR_CW-1:0]      count_r;
	logic [`TMR_CW-1:0]      count_nxt;
	logic [`TMR_DIVW-1:0]    div_cnt_r;
	logic [`TMR_DIVW-1:0]    div_cnt_nxt;
	logic [`TMR_DIVW-1:0]    div_max;
	logic                    src_prev_r;
	logic                    src_prev_nxt;
	logic [`TMR_DW-1:0]      prdata_r;
	logic [`TMR_DW-1:0]      prdata_nxt;
	tmr_pkg::chan_s          chan   [NCH];
	logic [NCH-1:0]          hit;
	logic [NCH-1:0]          ch_wr;
	logic                    src_lvl;
	logic                    tick;
	logic                    running;
	logic                    inc;
	logic                    ovf;
	logic                    wrap;
	logic                    wr_acc;
	logic                    rd_acc;
	logic                    setup;
	logic                    sel_ctrl;
	logic                    sel_stat;
	logic                    sel_iclr;
	logic                    sel_ien;
	logic                    sel_ivec;
	logic                    sel_count;
	logic                    sel_ch;
	logic                    mapped;
	logic [`TMR_AW-1:0]      ch_ofs;
	logic [`TMR_AW-3:0]      ch_idx;
	logic                    clr_wr;
	logic                    full_ctrl_wr;
	logic [31:0]             ctrl_merged;
	logic [31:0]             ien_merged;
	logic [NS-1:0]           pend;
	logic [NS-1:0]           iv_clr;
	logic [7:0]              iv_code;
	logic [`TMR_CW-1:0]      period;

	assign req = '{sel: PSEL, enable: PENABLE, write: PWRITE, addr: PADDR,
		wdata: PWDATA, strb: PSTRB};

	// Address decode
	always_comb
	begin
		sel_ctrl  = 1'b0;
		sel_stat  = 1'b0;
		sel_iclr  = 1'b0;
		sel_ien   = 1'b0;
		sel_ivec  = 1'b0;
		sel_count = 1'b0;
		sel_ch    = 1'b0;
		ch_ofs    = req.addr - `TMR_OFS_CH_BASE;
		ch_idx    = ch_ofs[`TMR_AW-1:2];
		if (req.addr == `TMR_OFS_CTRL)
		begin
			sel_ctrl = 1'b1;
		end
		else if (req.addr == `TMR_OFS_STAT)
		begin
			sel_stat = 1'b1;
		end
		else if (req.addr == `TMR_OFS_ICLR)
		begin
			sel_iclr = 1'b1;
		end
		else if (req.addr == `TMR_OFS_IEN)
		begin
			sel_ien = 1'b1;
		end
		else if (req.addr == `TMR_OFS_IVEC)
		begin
			sel_ivec = 1'b1;
		end
		else if (req.addr == `TMR_OFS_COUNT)
		begin
			sel_count = 1'b1;
		end
		else if ((req.addr >= `TMR_OFS_CH_BASE) && (ch_ofs[1:0] == 2'h0)
			&& (32'(ch_idx) < NCH))
		begin
			sel_ch = 1'b1;
		end
	end

	assign mapped  = sel_ctrl | sel_stat | sel_iclr | sel_ien | sel_ivec
		| sel_count | sel_ch;
	assign setup   = req.sel & ~req.enable;
	assign wr_acc  = req.sel & req.enable & req.write & mapped & ~POWER_UP_CLEAR;
	assign rd_acc  = req.sel & req.enable & ~req.write & mapped;
	// Zero-wait access phase; read data was latched during setup
	assign PREADY  = 1'b1;
	assign PSLVERR = req.sel & req.enable & ~mapped;
	assign PRDATA  = prdata_r;

	// RULE_02: clear bit acts on write, not stored
	assign clr_wr       = wr_acc & sel_ctrl & req.strb[0] & req.wdata[`TMR_CTRL_CLR];
	// RULE_08: full-word control write
	assign full_ctrl_wr = wr_acc & sel_ctrl & (req.strb == `TMR_STRB_FULL);
	assign ctrl_merged  = tmr_pkg::strb_merge(32'(ctrl_r), req.wdata, req.strb);
	assign ien_merged   = tmr_pkg::strb_merge(32'(ien_r), req.wdata, req.strb);

	// RULE_07: power-up clear wins over any write
	always_comb
	begin
		ctrl_nxt = ctrl_r;
		ien_nxt  = ien_r;
		if (POWER_UP_CLEAR)
		begin
			ctrl_nxt = `TMR_CTRL_RST;
			ien_nxt  = '0;
		end
		else if (wr_acc)
		begin
			if (sel_ctrl)
			begin
				ctrl_nxt       = tmr_pkg::ctrl_s'(ctrl_merged[$bits(tmr_pkg::ctrl_s)-1:0]);
				ctrl_nxt.clear = 1'b0;
			end
			else if (sel_ien)
			begin
				ien_nxt = ien_merged[NS-1:0];
			end
		end
	end

	// RULE_04: pin or auxiliary clock, sampled on CLK
	assign src_lvl      = ctrl_r.src_aux ? AUX_CLOCK : EXTERNAL_TIMER_CLOCK;
	assign src_prev_nxt = src_lvl;
	assign tick         = src_lvl & ~src_prev_r;
	assign running      = (ctrl_r.mode != tmr_pkg::MODE_STOP);
	assign div_max      = `TMR_DIVW'((4'h1 << ctrl_r.divider) - 4'h1);
	// RULE_10: every increment waits the full divide
	assign inc          = tick & running & (div_cnt_r == div_max) & ~clr_wr
		& ~POWER_UP_CLEAR;
	assign period       = chan[0].value;
	assign wrap         = (ctrl_r.mode == tmr_pkg::MODE_UP) ? (count_r >= period)
		: (count_r == '1);
	// RULE_01: only the pass from period (or top) to zero
	// RULE_03: a clear to zero cannot look like a wrap
	assign ovf          = inc & ((ctrl_r.mode == tmr_pkg::MODE_UP) ?
		(count_r == period) : (count_r == '1));

	always_comb
	begin
		div_cnt_nxt = div_cnt_r;
		count_nxt   = count_r;
		// RULE_02: clear forces zero even when running
		if (POWER_UP_CLEAR || clr_wr)
		begin
			div_cnt_nxt = '0;
			count_nxt   = '0;
		end
		else if (tick && running)
		begin
			div_cnt_nxt = (div_cnt_r == div_max) ? '0 : div_cnt_r + 1'b1;
			if (inc)
			begin
				count_nxt = wrap ? '0 : count_r + 1'b1;
			end
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < NCH; gi++)
		begin : g_ch
			assign ch_wr[gi] = wr_acc & sel_ch & (32'(ch_idx) == gi);
			tmr_channel u_ch (
				.clk       (CLK),
				.rst_n     (RST_N),
				.power_up_clear       (POWER_UP_CLEAR),
				.wr_en     (ch_wr[gi]),
				.wr_data   (req.wdata),
				.wr_strb   (req.strb),
				.inc       (inc),
				.count_nxt (count_nxt),
				.chan      (chan[gi]),
				.hit       (hit[gi])
			);
		end
	endgenerate

	// Vector: lowest pending enabled bit, channels before overflow
	assign pend = status_r & ien_r;
	always_comb
	begin
		iv_code = 8'h00;
		iv_clr  = '0;
		for (int i = NS - 1; i >= 0; i--)
		begin
			if (pend[i])
			begin
				iv_code = 8'((i + 1) * `TMR_IV_STEP);
				iv_clr  = NS'(1) << i;
			end
		end
	end

	// Hardware set wins over any software clear
	always_comb
	begin
		logic [NS-1:0] clr;
		clr = '0;
		if (wr_acc && sel_iclr)
		begin
			clr = req.wdata[NS-1:0];
		end
		if (rd_acc && sel_ivec)
		begin
			clr = clr | iv_clr;
		end
		if (full_ctrl_wr)
		begin
			clr = '1;
		end
		if (POWER_UP_CLEAR)
		begin
			status_nxt = '0;
		end
		else
		begin
			status_nxt = (status_r & ~clr) | {ovf, hit};
		end
	end

	assign IRQ = |pend;

	// Read data captured in the setup cycle
	always_comb
	begin
		prdata_nxt = prdata_r;
		if (setup)
		begin
			prdata_nxt = `TMR_WORD_RST;
			if (sel_ctrl)
			begin
				prdata_nxt = 32'(ctrl_r);
			end
			else if (sel_stat)
			begin
				prdata_nxt = 32'(status_r);
			end
			else if (sel_ien)
			begin
				prdata_nxt = 32'(ien_r);
			end
			else if (sel_ivec)
			begin
				prdata_nxt = 32'(iv_code);
			end
			else if (sel_count)
			begin
				prdata_nxt = 32'(count_r);
			end
			else if (sel_ch)
			begin
				prdata_nxt = 32'(chan[ch_idx[$clog2(NCH+1)-1:0]]);
			end
		end
	end

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			ctrl_r     <= `TMR_CTRL_RST;
			ien_r      <= '0;
			status_r   <= '0;
			count_r    <= '0;
			div_cnt_r  <= '0;
			src_prev_r <= 1'b0;
			prdata_r   <= `TMR_WORD_RST;
		end
		else
		begin
			ctrl_r     <= ctrl_nxt;
			ien_r      <= ien_nxt;
			status_r   <= status_nxt;
			count_r    <= count_nxt;
			div_cnt_r  <= div_cnt_nxt;
			src_prev_r <= src_prev_nxt;
			prdata_r   <= prdata_nxt;
		end
	end

endmodule : up_mode_timer_compare

/* tmr_defs.svh */
// Register offsets, field positions, reset values and widths of the timer
`ifndef TMR_DEFS_SVH
`define TMR_DEFS_SVH

`define TMR_AW          8
`define TMR_DW          32
`define TMR_CW          16
`define TMR_DIVW        3

`define TMR_OFS_CTRL    8'h00
`define TMR_OFS_STAT    8'h04
`define TMR_OFS_ICLR    8'h08
`define TMR_OFS_IEN     8'h0C
`define TMR_OFS_IVEC    8'h10
`define TMR_OFS_COUNT   8'h14
`define TMR_OFS_CH_BASE 8'h20

`define TMR_CTRL_RST    6'h00
`define TMR_CTRL_CLR    2
`define TMR_CH_RST      17'h0_0000
`define TMR_WORD_RST    32'h0000_0000
`define TMR_STRB_FULL   4'hF
`define TMR_IV_STEP     2

`endif

/* tmr_pkg.sv */
// Types shared by the timer top and its compare channels
`include "tmr_defs.svh"

package tmr_pkg;

	typedef enum logic [1:0] {MODE_STOP, MODE_UP, MODE_CONT, MODE_RSVD} mode_e;

	// Control word, low six bits of the control register
	typedef struct packed {
		logic [1:0] divider;
		logic       src_aux;
		logic       clear;
		mode_e      mode;
	} ctrl_s;

	// Channel word: compare enable above the compare value
	typedef struct packed {
		logic                   cmp_en;
		logic [`TMR_CW-1:0]     value;
	} chan_s;

	typedef struct packed {
		logic                   sel;
		logic                   enable;
		logic                   write;
		logic [`TMR_AW-1:0]     addr;
		logic [`TMR_DW-1:0]     wdata;
		logic [3:0]             strb;
	} apb_req_s;

	function automatic logic [31:0] strb_merge(input logic [31:0] old_w,
		input logic [31:0] new_w, input logic [3:0] strb);
		logic [31:0] res;
		res = old_w;
		for (int b = 0; b < 4; b++)
		begin
			if (strb[b])
			begin
				res[b*8 +: 8] = new_w[b*8 +: 8];
			end
		end
		return res;
	endfunction : strb_merge

endpackage : tmr_pkg

/* tmr_channel.sv */
// One compare channel: its register and its equality detector
`timescale 1ns/100ps
`include "tmr_defs.svh"

module tmr_channel (
	// Clock and resets
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	input  wire logic                 power_up_clear,
	// Register write
	input  wire logic                 wr_en,
	input  wire logic [`TMR_DW-1:0]   wr_data,
	input  wire logic [3:0]           wr_strb,
	// Counter view
	input  wire logic                 inc,
	input  wire logic [`TMR_CW-1:0]   count_nxt,
	// Results
	output tmr_pkg::chan_s            chan,
	output logic                      hit
);

	tmr_pkg::chan_s chan_r;
	tmr_pkg::chan_s chan_nxt;
	logic [31:0]    merged;

	always_comb
	begin
		merged   = tmr_pkg::strb_merge(32'(chan_r), wr_data, wr_strb);
		chan_nxt = chan_r;
		if (power_up_clear)
		begin
			chan_nxt = `TMR_CH_RST;
		end
		else if (wr_en)
		begin
			chan_nxt = tmr_pkg::chan_s'(merged[$bits(tmr_pkg::chan_s)-1:0]);
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			chan_r <= `TMR_CH_RST;
		end
		else
		begin
			chan_r <= chan_nxt;
		end
	end

	// RULE_05: compare on count becoming equal
	// RULE_06: live register, so a raised value still hits
	assign hit  = inc && chan_r.cmp_en && (count_nxt == chan_r.value);
	assign chan = chan_r;

endmodule : tmr_channel

/* up_mode_timer_compare_sva.sv */
// Concurrent checks on the timer's bus and interrupt ports
`timescale 1ns/100ps
`include "tmr_defs.svh"

module up_mode_timer_compare_sva #(
	parameter int NCH = 3
) (
	// Clock, reset, clear
	input wire logic               CLK,
	input wire logic               RST_N,
	input wire logic               POWER_UP_CLEAR,
	// APB
	input wire logic               PSEL,
	input wire logic               PENABLE,
	input wire logic               PWRITE,
	input wire logic [`TMR_AW-1:0] PADDR,
	input wire logic [`TMR_DW-1:0] PWDATA,
	input wire logic [3:0]         PSTRB,
	input wire logic [`TMR_DW-1:0] PRDATA,
	input wire logic               PREADY,
	input wire logic               PSLVERR,
	// Timer sources and interrupt
	input wire logic               EXTERNAL_TIMER_CLOCK,
	input wire logic               AUX_CLOCK,
	input wire logic               IRQ
);
	logic wr_acc;
	logic src;
	assign wr_acc = PSEL && PENABLE && PREADY && PWRITE;
	assign src = EXTERNAL_TIMER_CLOCK || AUX_CLOCK;
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	// No tick can be in flight
	sequence calm;
		!src [*3];
	endsequence
	sequence full_wr(a);
		wr_acc && PADDR == a && PSTRB == `TMR_STRB_FULL;
	endsequence
	a_puc_drops_irq: assert property (POWER_UP_CLEAR |=> !IRQ)
		else $error("irq after power-up clear");
	a_ctrl_init_clears: assert property (calm ##0 full_wr(`TMR_OFS_CTRL) |=> !IRQ)
		else $error("irq after control init");
	a_iclr_drops_irq: assert property (calm ##0 full_wr(`TMR_OFS_ICLR) ##0 &PWDATA[NCH:0]
		|=> !IRQ)
		else $error("irq after clear-all");
	a_mask_drops_irq: assert property (wr_acc && PADDR == `TMR_OFS_IEN && PSTRB[0]
		&& PWDATA[7:0] == 8'h00 |=> !IRQ)
		else $error("irq while masked");
	a_clear_zero_count: assert property (calm ##0 full_wr(`TMR_OFS_CTRL) ##0 PWDATA[2]
		##1 !src ##1 !src && PSEL && !PENABLE && PADDR == `TMR_OFS_COUNT |=> PRDATA == '0)
		else $error("count not zero after clear");
	a_rdata_holds: assert property (!(PSEL && !PENABLE) && !POWER_UP_CLEAR
		|=> $stable(PRDATA))
		else $error("read data moved outside setup");
	a_unmapped_err: assert property (PSEL && PENABLE && PADDR == 8'h18 |-> PSLVERR)
		else $error("no error on unmapped access");
	a_irq_has_cause: assert property ($rose(IRQ) |-> $past(wr_acc) || $past(src)
		|| $past(src, 2) || $past(src, 3) || $past(src, 4))
		else $error("irq rose without tick or write");
endmodule : up_mode_timer_compare_sva

bind up_mode_timer_compare up_mode_timer_compare_sva #(.NCH(NCH)) i_up_mode_timer_compare_sva (
	.CLK(CLK), .RST_N(RST_N), .POWER_UP_CLEAR(POWER_UP_CLEAR), .PSEL(PSEL),
	.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB),
	.PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .IRQ(IRQ),
	.EXTERNAL_TIMER_CLOCK(EXTERNAL_TIMER_CLOCK), .AUX_CLOCK(AUX_CLOCK));

/* up_mode_timer_compare_test.sv */
// Self-checking bench for the up mode timer
`timescale 1ns/100ps
`include "tmr_defs.svh"
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin fails++; \
	$display("mismatch %s exp %h got %h", n, e, g); end end

module up_mode_timer_compare_test;
	localparam int P = 4;
	logic        CLK, RST_N, POWER_UP_CLEAR, PSEL, PENABLE, PWRITE;
	logic [7:0]  PADDR;
	logic [31:0] PWDATA, PRDATA, e;
	logic [3:0]  PSTRB;
	logic        PREADY, PSLVERR, EXTERNAL_TIMER_CLOCK, AUX_CLOCK, IRQ;
	logic [31:0] exp_q[$];
	int          fails = 0;
	int          n_compared = 0;
	int          c;

	up_mode_timer_compare #(.NCH(3)) i_up_mode_timer_compare (.CLK(CLK), .RST_N(RST_N),
		.POWER_UP_CLEAR(POWER_UP_CLEAR), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
		.PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY),
		.PSLVERR(PSLVERR), .EXTERNAL_TIMER_CLOCK(EXTERNAL_TIMER_CLOCK),
		.AUX_CLOCK(AUX_CLOCK), .IRQ(IRQ));

	initial
	begin
		CLK = 1'b0;
		forever #12.5 CLK = ~CLK;
	end

	task automatic end_of_test;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_of_test

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		PSEL   <= 1'b1;
		PWRITE <= w;
		PADDR  <= a;
		PWDATA <= d;
		PSTRB  <= `TMR_STRB_FULL;
		@(posedge CLK);
		PENABLE <= 1'b1;
		do
			@(posedge CLK);
		while (PREADY !== 1'b1);
		PSEL    <= 1'b0;
		PENABLE <= 1'b0;
		@(posedge CLK);
	endtask : apb

	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		exp_q.push_back(x);
		apb(1'b0, a, 32'h0000_0000);
	endtask : rd

	// One timer edge per pass on the chosen source only
	task automatic tick(input logic aux, input int n);
		repeat (n)
		begin
			AUX_CLOCK            <= aux;
			EXTERNAL_TIMER_CLOCK <= !aux;
			repeat (2) @(posedge CLK);
			AUX_CLOCK            <= 1'b0;
			EXTERNAL_TIMER_CLOCK <= 1'b0;
			repeat (3) @(posedge CLK);
		end
	endtask : tick

	task automatic irq_is(input logic x);
		#1;
		`CHK("irq", x, IRQ)
		@(posedge CLK);
	endtask : irq_is

	// Read data is valid in the access cycle
	always @(posedge CLK)
	begin
		if (PSEL && PENABLE && PREADY)
		begin
			`CHK("slverr", PADDR == 8'h18, PSLVERR)
		end
		if (PSEL && PENABLE && !PWRITE && PREADY && exp_q.size() > 0)
		begin
			e = exp_q.pop_front();
			`CHK("read data", e, PRDATA)
		end
	end

	initial
	begin
		repeat (5000) @(posedge CLK);
		fails++;
		end_of_test();
	end

	initial
	begin
		{RST_N, POWER_UP_CLEAR, PSEL, PENABLE, PWRITE, PADDR, PWDATA, PSTRB} = '0;
		{EXTERNAL_TIMER_CLOCK, AUX_CLOCK} = 2'b00;
		void'($urandom(32'h7407));
		c = 1 + $urandom % 2;
		repeat (8) @(posedge CLK);
		RST_N <= 1'b1;
		@(posedge CLK);
		rd(`TMR_OFS_CTRL, 32'h0000_0000);
		rd(`TMR_OFS_IVEC, 32'h0000_0000);
		apb(1'b1, `TMR_OFS_CTRL, 32'h0000_0000);
		apb(1'b1, `TMR_OFS_IEN, 32'h0000_000F);
		apb(1'b1, `TMR_OFS_CH_BASE, 32'(P));
		apb(1'b1, `TMR_OFS_CTRL, 32'h0000_0005);
		for (int i = 1; i <= P; i++)
		begin
			tick(1'b0, 1);
			rd(`TMR_OFS_COUNT, 32'(i));
		end
		rd(`TMR_OFS_STAT, 32'h0000_0000);
		tick(1'b0, 1);
		irq_is(1'b1);
		rd(`TMR_OFS_IVEC, 32'h0000_0008);
		rd(`TMR_OFS_STAT, 32'h0000_0000);
		tick(1'b0, P);
		apb(1'b1, `TMR_OFS_CTRL, 32'h0000_0000);
		tick(1'b0, 1);
		rd(`TMR_OFS_COUNT, 32'(P));
		apb(1'b1, `TMR_OFS_CTRL, 32'h0000_0004);
		rd(`TMR_OFS_COUNT, 32'h0000_0000);
		apb(1'b1, `TMR_OFS_CTRL, 32'h0000_0001);
		tick(1'b0, 1);
		rd(`TMR_OFS_STAT, 32'h0000_0000);
		apb(1'b1, `TMR_OFS_CTRL, 32'h0000_0005);
		rd(`TMR_OFS_COUNT, 32'h0000_0000);
		apb(1'b1, `TMR_OFS_CH_BASE + 8'h04, 32'h0001_0000 | 32'(c));
		tick(1'b0, c);
		rd(`TMR_OFS_IVEC, 32'h0000_0004);
		apb(1'b1, `TMR_OFS_CH_BASE + 8'h04, 32'h0001_0000 | 32'(c + 1));
		tick(1'b0, 1);
		rd(`TMR_OFS_STAT, 32'h0000_0002);
		apb(1'b1, `TMR_OFS_IEN, 32'h0000_0000);
		irq_is(1'b0);
		apb(1'b1, `TMR_OFS_IEN, 32'h0000_000F);
		irq_is(1'b1);
		apb(1'b1, `TMR_OFS_ICLR, 32'h0000_000F);
		irq_is(1'b0);
		tick(1'b0, P - c);
		irq_is(1'b1);
		apb(1'b1, `TMR_OFS_CTRL, 32'h0000_0001);
		rd(`TMR_OFS_IVEC, 32'h0000_0000);
		// divide by four from the clear
		apb(1'b1, `TMR_OFS_CTRL, 32'h0000_0025);
		tick(1'b0, 3);
		rd(`TMR_OFS_COUNT, 32'h0000_0000);
		tick(1'b0, 1);
		rd(`TMR_OFS_COUNT, 32'h0000_0001);
		apb(1'b1, `TMR_OFS_CTRL, 32'h0000_000D);
		tick(1'b0, 2);
		rd(`TMR_OFS_COUNT, 32'h0000_0000);
		tick(1'b1, 1);
		apb(1'b1, 8'h18, $urandom);
		apb(1'b1, `TMR_OFS_COUNT, 32'h0000_0003);
		rd(`TMR_OFS_CTRL, 32'h0000_0009);
		rd(`TMR_OFS_COUNT, 32'h0000_0001);
		tick(1'b1, P);
		irq_is(1'b1);
		POWER_UP_CLEAR <= 1'b1;
		// Channel write lands inside the clear and must be lost
		apb(1'b1, `TMR_OFS_CH_BASE + 8'h04, 32'h0001_0000 | 32'(c + 2));
		POWER_UP_CLEAR <= 1'b0;
		irq_is(1'b0);
		rd(`TMR_OFS_CTRL, 32'h0000_0000);
		rd(`TMR_OFS_IVEC, 32'h0000_0000);
		rd(`TMR_OFS_COUNT, 32'h0000_0000);
		rd(`TMR_OFS_CH_BASE + 8'h04, 32'h0000_0000);
		// continuous mode runs past a zero period without a flag
		apb(1'b1, `TMR_OFS_CTRL, 32'h0000_000E);
		tick(1'b1, 2);
		rd(`TMR_OFS_COUNT, 32'h0000_0002);
		rd(`TMR_OFS_STAT, 32'h0000_0000);
		end_of_test();
	end
endmodule : up_mode_timer_compare_test
